// File: hw/hsx_pkg.sv
// Purpose: Shared constants and types for the store and exclusive-OR execution block
// Assumes: 32-bit APB, single 20 MHz clock pclk
// Notes:   Offsets are byte addresses of aligned words
package hsx_pkg;

  // Instruction word layout
  localparam int unsigned OPC_MSB    = 31;
  localparam int unsigned OPC_LSB    = 26;
  localparam int unsigned EFF_Z_BIT  = 25;
  localparam int unsigned EFF_C_BIT  = 24;
  localparam int unsigned EFF_R_BIT  = 23;
  localparam int unsigned EFF_I_BIT  = 22;
  localparam int unsigned DST_LSB    = 9;
  localparam int unsigned SRC_LSB    = 0;

  localparam logic [5:0] OPC_BYTE_STORE = 6'h00;
  localparam logic [5:0] OPC_WORD_STORE = 6'h01;
  localparam logic [5:0] OPC_LONG_STORE = 6'h02;
  localparam logic [5:0] OPC_XOR        = 6'h1B;
  localparam logic [5:0] OPC_UCOMPARE   = 6'h21;

  // Cycle counts
  localparam logic [7:0] ALU_CLKS     = 8'h04;
  localparam logic [7:0] HUB_MIN_CLKS = 8'h08;
  localparam logic [7:0] HUB_MAX_CLKS = 8'h17;

  // APB register offsets
  localparam logic [7:0] OFS_INSTR   = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_FLAGS   = 8'h08;
  localparam logic [7:0] OFS_CYCLES  = 8'h0C;
  localparam logic [7:0] OFS_RF_BASE = 8'h20;
  localparam logic [7:0] OFS_RF_LAST = 8'h3C;

  // Status bit positions
  localparam int unsigned STS_BUSY  = 0;
  localparam int unsigned STS_Z     = 1;
  localparam int unsigned STS_C     = 2;
  localparam int unsigned STS_LOAD  = 3;
  localparam int unsigned STS_UNSUP = 4;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0]  RST_CNT  = 8'h00;

  localparam int unsigned RF_DEPTH = 8;

  typedef enum logic [1:0] {
    HSX_SZ_BYTE,
    HSX_SZ_WORD,
    HSX_SZ_LONG
  } hsx_size_t;

endpackage : hsx_pkg

// File: hw/hsx_alu.sv
// Purpose: Exclusive-OR and unsigned compare datapath with flag results
// Assumes: Purely combinational, operands held stable by the caller
// Notes:   Parity is a reduction, no carry chain involved
`timescale 1ns/10ps
module hsx_alu
  import hsx_pkg::*;
(
  input  wire logic [31:0] d_val,
  input  wire logic [31:0] s_val,
  output logic      [31:0] xor_res,
  output logic             xor_zero,
  output logic             xor_parity,
  output logic             ops_eq,
  output logic             ops_lt
);

  always_comb
  begin
    xor_res    = d_val ^ s_val;
    xor_zero   = (xor_res == RST_WORD);  // [RULE_14]
    xor_parity = ^xor_res;               // [RULE_15]
    ops_eq     = (d_val == s_val);       // [RULE_12]
    ops_lt     = (d_val < s_val);
  end

endmodule : hsx_alu

// File: hw/hsx_store_fmt.sv
// Purpose: Aligns store address and data onto the 32-bit main-memory lanes
// Assumes: 14-bit byte address space
// Notes:   Z result depends only on the aligned address
`timescale 1ns/10ps
module hsx_store_fmt
  import hsx_pkg::*;
(
  input  wire hsx_size_t   size,
  input  wire logic [13:0] addr_in,
  input  wire logic [31:0] d_val,
  output logic      [13:0] addr_out,
  output logic      [31:0] wdata,
  output logic      [3:0]  be,
  output logic             z_out
);

  always_comb
  begin
    addr_out = addr_in;
    wdata    = d_val;
    be       = 4'hF;
    z_out    = 1'b0;
    case (size)
      HSX_SZ_BYTE:
      begin
        wdata = {4{d_val[7:0]}};                             // [RULE_01]
        be    = 4'h1 << addr_in[1:0];
        z_out = (addr_in[1:0] != 2'h0);                     // [RULE_07]
      end
      HSX_SZ_WORD:
      begin
        addr_out = {addr_in[13:1], 1'b0};
        wdata    = {2{d_val[15:0]}};                         // [RULE_02]
        be       = addr_in[1] ? 4'hC : 4'h3;
        z_out    = addr_in[1];                               // [RULE_08]
      end
      default:
      begin
        addr_out = {addr_in[13:2], 2'h0};                   // [RULE_09]
        wdata    = d_val;                                   // [RULE_03]
        be       = 4'hF;
        z_out    = 1'b0;
      end
    endcase
  end

endmodule : hsx_store_fmt

// File: hw/hsx_exec.sv
// Purpose: Executes shared-memory stores, exclusive-OR and unsigned compare for one core
// Assumes: APB master software, memory arbiter on pclk granting one slot per rotation
// Notes:   Register file is 8 words; operand fields use their low three bits
//
// How it works
// [RULE_01] Byte store waits for slot, writes destination bits 7:0 at source address.
// [RULE_02] Word store waits for slot, writes destination bits 15:0.
// [RULE_03] Long store waits for slot, writes all 32 destination bits.
// [RULE_04] Store opcode with result-write bit set decodes as same-size load instead.
// [RULE_05] Stores take 8 to 23 clocks depending on slot position.
// [RULE_06] Source is register or zero-extended 9-bit immediate; destination field supplies data.
// [RULE_07] Byte store with zero effect: Z set unless address is long-aligned.
// [RULE_08] Word store with zero effect: Z set unless bits 13:1 land on long.
// [RULE_09] Long store uses bits 13:2, always aligned, so zero effect clears Z.
// [RULE_10] Zero effect updates Z from result; otherwise Z holds.
// [RULE_11] Unsigned compare changes no flag unless effect bits ask.
// [RULE_12] Compare with zero effect sets Z when operands are equal.
// [RULE_13] Exclusive-OR takes 4 clocks, writes destination unless no-result.
// [RULE_14] Exclusive-OR zero effect sets Z when result is all zeros.
// [RULE_15] Exclusive-OR carry effect sets C to odd parity of result.
// [RULE_16] Carry effect updates C from result; otherwise C holds.
// [RULE_17] Carry effect on any store clears C.
`timescale 1ns/10ps
module hsx_exec
  import hsx_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hub_grant,
  output logic             hub_req,
  output logic             hub_we,
  output logic      [13:0] hub_addr,
  output logic      [31:0] hub_wdata,
  output logic      [3:0]  hub_be
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ALU,
    ST_HUB
  } hsx_state_t;

  hsx_state_t  state_q;
  logic [31:0] instr_q;
  logic [31:0] dval_q;
  logic [31:0] sval_q;
  logic [7:0]  cnt_q;
  logic [7:0]  cycles_q;
  logic        z_q;
  logic        c_q;
  logic        load_q;
  logic        unsup_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        hub_req_q;
  logic [13:0] hub_addr_q;
  logic [31:0] hub_wdata_q;
  logic [3:0]  hub_be_q;
  logic [31:0] rf_q [RF_DEPTH];

  logic        apb_setup;
  logic        apb_done;
  logic        busy;
  logic        start;
  logic        rf_hit;
  logic [2:0]  rf_idx;
  logic [31:0] rd_d;
  logic        err_d;
  logic [5:0]  opc;
  logic        is_store;
  logic [31:0] dval_d;
  logic [31:0] sval_d;
  hsx_size_t   size_d;
  logic        fin_alu;
  logic        fin_hub;
  logic [31:0] xor_res;
  logic        xor_zero;
  logic        xor_parity;
  logic        ops_eq;
  logic        ops_lt;
  logic [13:0] st_addr;
  logic [31:0] st_wdata;
  logic [3:0]  st_be;
  logic        st_z;

  assign apb_setup = psel && !penable;
  assign apb_done  = psel && penable && pready_q;
  assign busy      = (state_q != ST_IDLE);
  assign rf_hit    = (paddr >= OFS_RF_BASE) && (paddr <= OFS_RF_LAST) && (paddr[1:0] == 2'h0);
  assign rf_idx    = paddr[4:2];
  // Start ignored while busy so operands cannot change mid-instruction
  assign start     = apb_done && pwrite && (paddr == OFS_INSTR) && !busy;

  // Decode of the instruction being written
  assign opc      = pwdata[OPC_MSB:OPC_LSB];
  assign is_store = (opc == OPC_BYTE_STORE) || (opc == OPC_WORD_STORE) ||
                    (opc == OPC_LONG_STORE);
  assign dval_d   = rf_q[pwdata[DST_LSB +: 3]];                                 // [RULE_06]
  assign sval_d   = pwdata[EFF_I_BIT] ? {23'h000000, pwdata[SRC_LSB +: 9]}      // [RULE_06]
                                      : rf_q[pwdata[SRC_LSB +: 3]];

  always_comb
  begin
    size_d = HSX_SZ_LONG;
    if (instr_q[OPC_MSB:OPC_LSB] == OPC_BYTE_STORE)
    begin
      size_d = HSX_SZ_BYTE;
    end
    else if (instr_q[OPC_MSB:OPC_LSB] == OPC_WORD_STORE)
    begin
      size_d = HSX_SZ_WORD;
    end
  end

  hsx_alu u_alu (
    .d_val      (dval_q),
    .s_val      (sval_q),
    .xor_res    (xor_res),
    .xor_zero   (xor_zero),
    .xor_parity (xor_parity),
    .ops_eq     (ops_eq),
    .ops_lt     (ops_lt)
  );

  hsx_store_fmt u_fmt (
    .size     (size_d),
    .addr_in  (sval_q[13:0]),
    .d_val    (dval_q),
    .addr_out (st_addr),
    .wdata    (st_wdata),
    .be       (st_be),
    .z_out    (st_z)
  );

  assign fin_alu = (state_q == ST_ALU) && (cnt_q == ALU_CLKS - 8'h01);          // [RULE_13]
  // Memory write happens on the edge where request and grant meet
  assign fin_hub = (state_q == ST_HUB) && hub_req_q && hub_grant;               // [RULE_05]

  // APB read mux and decode
  always_comb
  begin
    rd_d  = RST_WORD;
    err_d = 1'b0;
    if (paddr == OFS_INSTR)
    begin
      rd_d = instr_q;
    end
    else if (paddr == OFS_STATUS)
    begin
      rd_d[STS_BUSY]  = busy;
      rd_d[STS_Z]     = z_q;
      rd_d[STS_C]     = c_q;
      rd_d[STS_LOAD]  = load_q;
      rd_d[STS_UNSUP] = unsup_q;
    end
    else if (paddr == OFS_FLAGS)
    begin
      rd_d[1:0] = {c_q, z_q};
    end
    else if (paddr == OFS_CYCLES)
    begin
      rd_d[7:0] = cycles_q;
    end
    else if (rf_hit)
    begin
      rd_d = rf_q[rf_idx];
    end
    else
    begin
      err_d = 1'b1;
    end
  end

  // One wait-free access phase; read data captured at setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= RST_WORD;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata_q  <= pwrite ? RST_WORD : rd_d;
      pready_q  <= 1'b1;
      pslverr_q <= err_d;
    end
    else
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Sequencer and cycle counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q  <= ST_IDLE;
      cnt_q    <= RST_CNT;
      cycles_q <= RST_CNT;
      instr_q  <= RST_WORD;
      dval_q   <= RST_WORD;
      sval_q   <= RST_WORD;
      load_q   <= 1'b0;
      unsup_q  <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (start)
          begin
            instr_q <= pwdata;
            dval_q  <= dval_d;
            sval_q  <= sval_d;
            cnt_q   <= RST_CNT;
            load_q  <= is_store && pwdata[EFF_R_BIT];                           // [RULE_04]
            unsup_q <= !is_store && (opc != OPC_XOR) && (opc != OPC_UCOMPARE);
            // Load forms are not executed here; they retire as plain ALU slots
            state_q <= (is_store && !pwdata[EFF_R_BIT]) ? ST_HUB : ST_ALU;      // [RULE_04]
          end
        end
        ST_ALU:
        begin
          cnt_q <= cnt_q + 8'h01;
          if (fin_alu)
          begin
            cycles_q <= cnt_q + 8'h01;
            state_q  <= ST_IDLE;
          end
        end
        default:
        begin
          cnt_q <= cnt_q + 8'h01;
          if (fin_hub)
          begin
            cycles_q <= cnt_q + 8'h01;
            state_q  <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Main-memory request: raised so it first meets a grant after the minimum
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hub_req_q   <= 1'b0;
      hub_addr_q  <= 14'h0000;
      hub_wdata_q <= RST_WORD;
      hub_be_q    <= 4'h0;
    end
    else if (fin_hub)
    begin
      hub_req_q <= 1'b0;
    end
    else if ((state_q == ST_HUB) && (cnt_q == HUB_MIN_CLKS - 8'h02))            // [RULE_05]
    begin
      hub_req_q   <= 1'b1;                                                      // [RULE_01]
      hub_addr_q  <= st_addr;
      hub_wdata_q <= st_wdata;
      hub_be_q    <= st_be;
    end
  end

  // Flags: execution result wins over a software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      z_q <= 1'b0;
      c_q <= 1'b0;
    end
    else if (fin_hub)
    begin
      if (instr_q[EFF_Z_BIT])                                                   // [RULE_10]
      begin
        z_q <= st_z;                                                            // [RULE_07]
      end
      if (instr_q[EFF_C_BIT])                                                   // [RULE_16]
      begin
        c_q <= 1'b0;                                                            // [RULE_17]
      end
    end
    else if (fin_alu && !load_q && !unsup_q)
    begin
      // Compare touches flags only through the effect bits
      if (instr_q[EFF_Z_BIT])                                                   // [RULE_11]
      begin
        z_q <= (instr_q[OPC_MSB:OPC_LSB] == OPC_XOR) ? xor_zero : ops_eq;       // [RULE_12]
      end
      if (instr_q[EFF_C_BIT])                                                   // [RULE_16]
      begin
        c_q <= (instr_q[OPC_MSB:OPC_LSB] == OPC_XOR) ? xor_parity : ops_lt;     // [RULE_15]
      end
    end
    else if (apb_done && pwrite && (paddr == OFS_FLAGS) && !busy)
    begin
      z_q <= pwdata[0];
      c_q <= pwdata[1];
    end
  end

  // Register file
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < RF_DEPTH; i++)
      begin
        rf_q[i] <= RST_WORD;
      end
    end
    else if (fin_alu && (instr_q[OPC_MSB:OPC_LSB] == OPC_XOR) && instr_q[EFF_R_BIT])
    begin
      rf_q[instr_q[DST_LSB +: 3]] <= xor_res;                                   // [RULE_13]
    end
    else if (apb_done && pwrite && rf_hit && !busy)
    begin
      rf_q[rf_idx] <= pwdata;
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign hub_req   = hub_req_q;
  assign hub_we    = hub_req_q;
  assign hub_addr  = hub_addr_q;
  assign hub_wdata = hub_wdata_q;
  assign hub_be    = hub_be_q;

endmodule : hsx_exec

// File: verification/hsx_exec_asserts.sv
// Purpose: Port assertions for the store and exclusive-OR block
// Assumes: One clock pclk, async active-low presetn
// Notes:   Sees only top-level ports, attached by bind
`timescale 1ns/10ps
module hsx_exec_asserts
  import hsx_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        hub_grant,
  input wire logic        hub_req,
  input wire logic        hub_we,
  input wire logic [13:0] hub_addr,
  input wire logic [31:0] hub_wdata,
  input wire logic [3:0]  hub_be
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic st_go;
  // Only stores without the result bit reach the memory port
  assign st_go = psel && penable && pready && pwrite && paddr == OFS_INSTR &&
                 pwdata[31:26] inside {OPC_BYTE_STORE, OPC_WORD_STORE, OPC_LONG_STORE} &&
                 !pwdata[EFF_R_BIT];

  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  store_start_a: assert property (st_go |-> !hub_req [*8] ##1 hub_req)
    else $error("store request at wrong cycle");
  store_bound_a: assert property ($rose(hub_req) |-> ##[1:16] !hub_req)
    else $error("store not finished within slot rotation");
  hold_req_a: assert property (hub_req && !hub_grant |=> hub_req && $stable(hub_addr) &&
    $stable(hub_wdata) && $stable(hub_be)) else $error("store request changed early");
  release_a: assert property (hub_req && hub_grant |=> !hub_req)
    else $error("store request not released");
  we_match_a: assert property (hub_we == hub_req)
    else $error("write strobe differs from request");
  byte_lane_a: assert property (hub_req && $onehot(hub_be) |->
    hub_be == (4'h1 << hub_addr[1:0]) && hub_wdata == {4{hub_wdata[7:0]}})
    else $error("byte lane wrong");
  word_lane_a: assert property (hub_req && $countones(hub_be) == 2 |->
    !hub_addr[0] && hub_be == (hub_addr[1] ? 4'hC : 4'h3) &&
    hub_wdata[31:16] == hub_wdata[15:0]) else $error("word lane wrong");
  long_lane_a: assert property (hub_req && hub_be == 4'hF |-> hub_addr[1:0] == 2'h0)
    else $error("long store not aligned");

  cover property (st_go);
  cover property (pslverr);
  cover property (hub_req && hub_grant && hub_be == 4'hF);
endmodule : hsx_exec_asserts

bind hsx_exec hsx_exec_asserts i_asserts (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .hub_grant, .hub_req, .hub_we, .hub_addr,
  .hub_wdata, .hub_be);

// File: verification/hsx_arb_model.sv
// Purpose: Shared-memory arbiter model offering one slot per 16 clocks
// Assumes: Same clock as the core
// Notes:   Free-running rotation, so waits vary from prompt to slow
`timescale 1ns/10ps
module hsx_arb_model
  import hsx_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic hub_req,
  output logic      hub_grant
);
  logic [3:0] slot_q;

  // Rotation runs whether or not the core asks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slot_q <= 4'h0;
    else
      slot_q <= slot_q + 4'h1;
  end

  assign hub_grant = (slot_q == 4'hF) && hub_req;
endmodule : hsx_arb_model

// File: verification/hsx_exec_tb_top.sv
// Purpose: Self-checking bench for the store and exclusive-OR block
// Assumes: APB master tasks, arbiter model on the memory side
// Notes:   Ordinary cases in a row table, reset and refusals after it
`timescale 1ns/10ps
module hsx_exec_tb_top;
  import hsx_pkg::*;
  typedef struct packed {
    logic [31:0] ins;
    logic [31:0] d;
    logic [31:0] s;
    logic [1:0]  pf;
    logic [31:0] res;
    logic [1:0]  fl;
    logic [13:0] ma;
    logic [31:0] mw;
    logic [3:0]  mb;
  } hsx_row_t;
  localparam logic [5:0]  XR = OPC_XOR;
  localparam logic [5:0]  CP = OPC_UCOMPARE;
  localparam logic [5:0]  BS = OPC_BYTE_STORE;
  localparam logic [5:0]  WS = OPC_WORD_STORE;
  localparam logic [5:0]  LS = OPC_LONG_STORE;
  localparam logic [31:0] DV = 32'h1122_3344;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hub_grant;
  logic        hub_req;
  logic        hub_we;
  logic [13:0] hub_addr;
  logic [31:0] hub_wdata;
  logic [3:0]  hub_be;
  logic [13:0] cap_a;
  logic [31:0] cap_w;
  logic [3:0]  cap_b;
  logic [31:0] v;
  logic        e;
  int          n_fail;
  int          n_tests;
  int          cyc;
  hsx_row_t    rows [17];

  hsx_exec i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .hub_grant, .hub_req, .hub_we, .hub_addr, .hub_wdata, .hub_be);
  hsx_arb_model i_arb (.pclk, .presetn, .hub_req, .hub_grant);

  always #25 pclk = ~pclk;

  // Memory write capture and hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (hub_req === 1'b1 && hub_grant === 1'b1)
    begin
      cap_a = hub_addr;
      cap_w = hub_wdata;
      cap_b = hub_be;
    end
    if (cyc == 20000)
    begin
      n_fail++;
      final_report();
    end
  end

  function automatic logic [31:0] mk(input logic [5:0] op, input logic [3:0] zcri,
                                     input logic [8:0] src);
    return {op, zcri, 4'hF, 9'd1, src};
  endfunction : mk

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk32

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rv, output logic er);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a wait for the answer
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        er;
    apb(1'b1, a, d, x, er);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    logic er;
    apb(1'b0, a, 32'h0, x, er);
  endtask : rd

  task automatic run(input hsx_row_t r);
    logic [31:0] x;
    wr(OFS_RF_BASE + 8'h04, r.d);
    wr(OFS_RF_BASE + 8'h08, r.s);
    wr(OFS_FLAGS, {30'h0, r.pf});
    cap_a = 14'h0;
    cap_w = 32'h0;
    cap_b = 4'h0;
    wr(OFS_INSTR, r.ins);
    x = 32'h1;
    // Poll busy, a new instruction while busy would be dropped
    while (x[STS_BUSY] !== 1'b0)
      rd(OFS_STATUS, x);
    chk32({31'h0, x[STS_LOAD]}, {31'h0, r.ins[31:26] <= LS && r.ins[EFF_R_BIT]});
    rd(OFS_RF_BASE + 8'h04, x);
    chk32(x, r.res);
    rd(OFS_FLAGS, x);
    chk32(x, {30'h0, r.fl});
    chk32({14'h0, cap_b, cap_a}, {14'h0, r.mb, r.ma});
    chk32(cap_w, r.mw);
    rd(OFS_CYCLES, x);
    if (r.mb != 4'h0)
      chk32({31'h0, x >= 32'd8 && x <= 32'd23}, 32'h1);
    else
      chk32(x, 32'd4);
  endtask : run

  task automatic final_report;
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  initial
  begin
    pclk    = 1'b0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    // Flags field is {C, Z}; presets differ from results where the effect is on, except the load and unsupported rows, which keep their presets
    rows = '{
      '{mk(XR, 4'hE, 9'd2), 32'hA, 32'h5, 2'h3, 32'hF, 2'h0, 14'h0, 32'h0, 4'h0},
      '{mk(XR, 4'hE, 9'd2), 32'hA, 32'h7, 2'h1, 32'hD, 2'h2, 14'h0, 32'h0, 4'h0},
      '{mk(XR, 4'hE, 9'd2), 32'hA, 32'hA, 2'h2, 32'h0, 2'h1, 14'h0, 32'h0, 4'h0},
      '{mk(XR, 4'h8, 9'd2), 32'hA, 32'hA, 2'h2, 32'hA, 2'h3, 14'h0, 32'h0, 4'h0},
      '{mk(XR, 4'h3, 9'h1FF), 32'h0, 32'h0, 2'h3, 32'h1FF, 2'h3, 14'h0, 32'h0, 4'h0},
      '{mk(CP, 4'hC, 9'd2), 32'h5, 32'h5, 2'h2, 32'h5, 2'h1, 14'h0, 32'h0, 4'h0},
      '{mk(CP, 4'h8, 9'd2), 32'h4, 32'h5, 2'h3, 32'h4, 2'h2, 14'h0, 32'h0, 4'h0},
      '{mk(CP, 4'h0, 9'd2), 32'h5, 32'h5, 2'h0, 32'h5, 2'h0, 14'h0, 32'h0, 4'h0},
      '{mk(BS, 4'hD, 9'h005), DV, 32'h0, 2'h2, DV, 2'h1, 14'h005, 32'h4444_4444, 4'h2},
      '{mk(BS, 4'hD, 9'h004), DV, 32'h0, 2'h3, DV, 2'h0, 14'h004, 32'h4444_4444, 4'h1},
      '{mk(WS, 4'hD, 9'h007), DV, 32'h0, 2'h2, DV, 2'h1, 14'h006, 32'h3344_3344, 4'hC},
      '{mk(WS, 4'hD, 9'h008), DV, 32'h0, 2'h3, DV, 2'h0, 14'h008, 32'h3344_3344, 4'h3},
      '{mk(LS, 4'hD, 9'h00B), DV, 32'h0, 2'h3, DV, 2'h0, 14'h008, DV, 4'hF},
      '{mk(LS, 4'h0, 9'd2), DV, 32'h3FFF, 2'h3, DV, 2'h3, 14'h3FFC, DV, 4'hF},
      '{mk(BS, 4'hE, 9'h005), DV, 32'h0, 2'h0, DV, 2'h0, 14'h0, 32'h0, 4'h0},
      '{mk(LS, 4'hA, 9'h008), DV, 32'h0, 2'h1, DV, 2'h1, 14'h0, 32'h0, 4'h0},
      '{mk(6'h3E, 4'hE, 9'd2), 32'hA, 32'h5, 2'h2, 32'hA, 2'h2, 14'h0, 32'h0, 4'h0}};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
      run(rows[i]);
    apb(1'b0, 8'h10, 32'h0, v, e);
    chk32({31'h0, e}, 32'h1);
    chk32(v, 32'h0);
    // Reset in the middle of a store must drop the request and clear state
    wr(OFS_INSTR, mk(LS, 4'hC, 9'h008));
    // Reset only once the request stands, so clearing it is observable
    @(posedge pclk iff hub_req === 1'b1);
    chk32({31'h0, hub_req}, 32'h1);
    presetn <= 1'b0;
    @(posedge pclk);
    chk32({31'h0, hub_req}, 32'h0);
    presetn <= 1'b1;
    rd(OFS_STATUS, v);
    chk32(v, RST_WORD);
    rd(OFS_FLAGS, v);
    chk32(v, RST_WORD);
    rd(OFS_RF_BASE + 8'h04, v);
    chk32(v, RST_WORD);
    final_report();
  end
endmodule : hsx_exec_tb_top
